// [rtl/adcrs_pkg.sv]
// adcrs_pkg: register map, field positions and reset values of the converter status block
// assumes a 32-bit apb slave with one aligned word per register
package adcrs_pkg;
    localparam int          NCH            = 8;
    localparam int          RES_W          = 10;
    // register byte offsets
    localparam logic [11:0] OFF_CTRL       = 12'h000;
    localparam logic [11:0] OFF_MODE       = 12'h004;
    localparam logic [11:0] OFF_CHEN       = 12'h010;
    localparam logic [11:0] OFF_CHDIS      = 12'h014;
    localparam logic [11:0] OFF_CHSTAT     = 12'h018;
    localparam logic [11:0] OFF_STATUS     = 12'h01c;
    localparam logic [11:0] OFF_LAST       = 12'h020;
    localparam logic [11:0] OFF_IEN        = 12'h024;
    localparam logic [11:0] OFF_IMASK      = 12'h02c;
    localparam logic [11:0] OFF_CHRES0     = 12'h030;
    localparam logic [11:0] OFF_CHRES_END  = 12'h04c;
    // field positions
    localparam int          CTRL_START_BIT = 1;
    localparam int          MODE_PDOWN_BIT = 5;
    localparam int          ST_OVR_LSB     = 8;
    localparam int          ST_FRESH_BIT   = 16;
    localparam int          ST_GOVR_BIT    = 17;
    localparam int          LAST_CH_LSB    = 12;
    // reset values
    localparam logic [7:0]  CHEN_RST       = 8'h00;
    localparam logic [31:0] MASK_RST       = 32'h0000_0000;
endpackage

// [rtl/adcrs_apb.sv]
`timescale 1ns/1ps
// adcrs_apb: apb slave decode, zero wait state, error on unmapped offset
// assumes the apb master holds each request until pready is sampled high
module adcrs_apb
(
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    output logic             pready,
    output logic             pslverr,
    output logic             acc,
    output logic             wr,
    output logic             rd,
    output logic             mapped
);
    import adcrs_pkg::*;

    // single access cycle answers at once; no state needed here
    always_comb
    begin
        acc     = psel & penable;
        wr      = acc & pwrite;
        rd      = acc & ~pwrite;
        pready  = psel & penable;
        // the two holes below the enable word are refused, not read as zero
        mapped  = (paddr[1:0] == 2'h0) &&
                  ((paddr == OFF_CTRL) || (paddr == OFF_MODE)
                  || ((paddr >= OFF_CHEN) && (paddr <= OFF_LAST)) || (paddr == OFF_IEN)
                  || (paddr == OFF_IEN + 12'h004) || (paddr == OFF_IMASK)
                  || ((paddr >= OFF_CHRES0) && (paddr <= OFF_CHRES_END)));
        pslverr = acc & ~mapped;
    end
endmodule

// [rtl/adcrs_top.sv]
`timescale 1ns/1ps
// adcrs_top: converter result registers, done/overrun/fresh flags, deferred power-down
// assumes the sampling core pulses EOC_VALID for one cycle per finished conversion
// What this block does
// - fresh flag cleared only by last-result read
// - fresh flag set only when data stored
// - channel read never blocks fresh flag set
// - disable elsewhere never blocks fresh flag set
// - status read clears global overrun, new wins
// - global overrun set despite other channel read
// - disable elsewhere never blocks overrun flags
// - done cleared by channel or last read
// - status read clears channel overrun, new wins
// - disabled channel never raises done flag
// - channel read clears only its own done
// - power-down applied after next conversion completes
module adcrs_top
(
    input  wire logic                            CORE_CLK,
    input  wire logic                            RST_B,
    input  wire logic                            PSEL,
    input  wire logic                            PENABLE,
    input  wire logic                            PWRITE,
    input  wire logic [11:0]                     PADDR,
    input  wire logic [31:0]                     PWDATA,
    output logic      [31:0]                     PRDATA,
    output logic                                 PREADY,
    output logic                                 PSLVERR,
    input  wire logic                            EOC_VALID,
    input  wire logic [2:0]                      EOC_CH,
    input  wire logic [adcrs_pkg::RES_W-1:0]     EOC_DATA,
    input  wire logic                            CONV_BUSY,
    output logic                                 CONV_START,
    output logic                                 POWER_DOWN,
    output logic      [adcrs_pkg::NCH-1:0]       CH_ENABLE,
    output logic                                 IRQ
);
    import adcrs_pkg::*;

    logic                 acc;
    logic                 wr;
    logic                 rd;
    logic                 mapped;
    logic [NCH-1:0]       chen_q;
    logic [NCH-1:0]       done_q;
    logic [NCH-1:0]       ovr_q;
    logic                 fresh_q;
    logic                 govr_q;
    logic [RES_W-1:0]     res_q [NCH];
    logic [RES_W-1:0]     last_q;
    logic [2:0]           last_ch_q;
    logic                 pd_opt_q;
    logic                 pd_q;
    logic                 start_q;
    logic [31:0]          mask_q;
    logic [31:0]          prdata_q;
    logic [31:0]          status_w;
    logic                 rd_status;
    logic                 rd_last;
    logic [NCH-1:0]       rd_chres;
    logic                 store;
    logic [NCH-1:0]       eoc_hit;

    adcrs_apb u_apb
    (
        .psel    (PSEL),
        .penable (PENABLE),
        .pwrite  (PWRITE),
        .paddr   (PADDR),
        .pready  (PREADY),
        .pslverr (PSLVERR),
        .acc     (acc),
        .wr      (wr),
        .rd      (rd),
        .mapped  (mapped)
    );

    // read strobes; each decoded from the exact word offset
    assign rd_status = rd && (PADDR == OFF_STATUS);
    assign rd_last   = rd && (PADDR == OFF_LAST);
    // a conversion counts only if its channel is still enabled now
    assign store     = EOC_VALID && chen_q[EOC_CH];

    // per-channel decode, one generate loop
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            assign rd_chres[g] = rd && (PADDR == OFF_CHRES0 + 12'(4 * g));
            assign eoc_hit[g]  = store && (EOC_CH == 3'(g));

            // done: set wins over clear so a simultaneous read never eats it
            always_ff @(posedge CORE_CLK)
            begin
                if (!RST_B)
                    done_q[g] <= 1'b0;
                else if (eoc_hit[g])
                    done_q[g] <= 1'b1;
                else if (rd_chres[g] || rd_last)
                    done_q[g] <= 1'b0;
            end

            // channel overrun: a new overrun beats a status-read clear
            always_ff @(posedge CORE_CLK)
            begin
                if (!RST_B)
                    ovr_q[g] <= 1'b0;
                else if (eoc_hit[g] && done_q[g])
                    ovr_q[g] <= 1'b1;
                else if (rd_status)
                    ovr_q[g] <= 1'b0;
            end

            // result storage per channel
            always_ff @(posedge CORE_CLK)
            begin
                if (!RST_B)
                    res_q[g] <= '0;
                else if (eoc_hit[g])
                    res_q[g] <= EOC_DATA;
            end
        end
    endgenerate

    // last result; disable of another channel has no bearing here
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            last_q    <= '0;
            last_ch_q <= 3'h0;
        end
        else if (store)
        begin
            last_q    <= EOC_DATA;
            last_ch_q <= EOC_CH;
        end
    end

    // fresh flag: only a last-result read clears it, new store wins
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
            fresh_q <= 1'b0;
        else if (store)
            fresh_q <= 1'b1;
        else if (rd_last)
            fresh_q <= 1'b0;
    end

    // global overrun: store while fresh already set; new overrun beats clear
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
            govr_q <= 1'b0;
        else if (store && fresh_q)
            govr_q <= 1'b1;
        else if (rd_status)
            govr_q <= 1'b0;
    end

    // channel enable and disable by write-one registers
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
            chen_q <= CHEN_RST;
        else if (wr && PADDR == OFF_CHEN)
            chen_q <= chen_q | PWDATA[NCH-1:0];
        else if (wr && PADDR == OFF_CHDIS)
            chen_q <= chen_q & ~PWDATA[NCH-1:0];
    end

    // mode option and start pulse
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
        begin
            pd_opt_q <= 1'b0;
            start_q  <= 1'b0;
        end
        else
        begin
            if (wr && PADDR == OFF_MODE)
                pd_opt_q <= PWDATA[MODE_PDOWN_BIT];
            start_q <= wr && (PADDR == OFF_CTRL) && PWDATA[CTRL_START_BIT];
        end
    end

    // power-down only engages at a conversion end, mirroring the core's idle
    // limitation; software gets it fast by starting one conversion
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
            pd_q <= 1'b0;
        else if (!pd_opt_q)
            pd_q <= 1'b0;
        else if (EOC_VALID)
            pd_q <= 1'b1;
    end

    // interrupt mask: set and clear by write-one
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
            mask_q <= MASK_RST;
        else if (wr && PADDR == OFF_IEN)
            mask_q <= mask_q | PWDATA;
        else if (wr && PADDR == OFF_IEN + 12'h004)
            mask_q <= mask_q & ~PWDATA;
    end

    // status word; sticky bits above are cleared by reads as the flags demand
    always_comb
    begin
        status_w                                  = 32'h0;
        status_w[NCH-1:0]                         = done_q;
        status_w[ST_OVR_LSB +: NCH]               = ovr_q;
        status_w[ST_FRESH_BIT]                    = fresh_q;
        status_w[ST_GOVR_BIT]                     = govr_q;
    end

    // read data registered in the setup cycle so prdata comes from flops
    always_ff @(posedge CORE_CLK)
    begin
        if (!RST_B)
            prdata_q <= 32'h0;
        else if (PSEL && !PENABLE && !PWRITE)
        begin
            if (PADDR == OFF_MODE)
                prdata_q <= 32'(pd_opt_q) << MODE_PDOWN_BIT;
            else if (PADDR == OFF_CHSTAT)
                prdata_q <= 32'(chen_q);
            else if (PADDR == OFF_STATUS)
                prdata_q <= status_w;
            else if (PADDR == OFF_LAST)
                prdata_q <= 32'(last_q) | (32'(last_ch_q) << LAST_CH_LSB);
            else if (PADDR == OFF_IMASK)
                prdata_q <= mask_q;
            else if (PADDR >= OFF_CHRES0 && PADDR <= OFF_CHRES_END)
                prdata_q <= 32'(res_q[PADDR[4:2] - 3'h4]);
            else
                prdata_q <= 32'h0;
        end
    end

    assign PRDATA     = prdata_q;
    assign CONV_START = start_q;
    assign POWER_DOWN = pd_q;
    assign CH_ENABLE  = chen_q;
    assign IRQ        = |(status_w & mask_q);

    // assertions
    property p_fresh_set;
        @(posedge CORE_CLK) disable iff (!RST_B) store |=> fresh_q;
    endproperty
    a_fresh_set: assert property (p_fresh_set) else $error("fresh flag missed");

    property p_fresh_hold;
        @(posedge CORE_CLK) disable iff (!RST_B)
            fresh_q && !rd_last |=> fresh_q;
    endproperty
    a_fresh_hold: assert property (p_fresh_hold) else $error("fresh cleared wrongly");

    property p_fresh_clr;
        @(posedge CORE_CLK) disable iff (!RST_B) rd_last && !store |=> !fresh_q;
    endproperty
    a_fresh_clr: assert property (p_fresh_clr) else $error("fresh not cleared");

    property p_govr;
        @(posedge CORE_CLK) disable iff (!RST_B) store && fresh_q |=> govr_q;
    endproperty
    a_govr: assert property (p_govr) else $error("global overrun missed");

    property p_govr_clr;
        @(posedge CORE_CLK) disable iff (!RST_B)
            rd_status && !(store && fresh_q) |=> !govr_q;
    endproperty
    a_govr_clr: assert property (p_govr_clr) else $error("global overrun kept");

    property p_no_done_dis;
        @(posedge CORE_CLK) disable iff (!RST_B)
            EOC_VALID && !chen_q[EOC_CH] && !done_q[EOC_CH] |=> !done_q[$past(EOC_CH)];
    endproperty
    a_no_done_dis: assert property (p_no_done_dis) else $error("done on disabled");

    property p_ovr_clr;
        @(posedge CORE_CLK) disable iff (!RST_B)
            rd_status && !store |=> ovr_q == 8'h00;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");

    sequence s_pd_req;
        pd_opt_q && !pd_q && !EOC_VALID && !CONV_BUSY;
    endsequence
    property p_pd_wait;
        @(posedge CORE_CLK) disable iff (!RST_B) s_pd_req ##1 pd_opt_q |-> !pd_q;
    endproperty
    a_pd_wait: assert property (p_pd_wait) else $error("power-down too early");

    property p_pd_set;
        @(posedge CORE_CLK) disable iff (!RST_B) pd_opt_q && EOC_VALID |=> pd_q;
    endproperty
    a_pd_set: assert property (p_pd_set) else $error("power-down not applied");

    // a read of another channel racing a store must not hide it
    property p_fresh_race;
        @(posedge CORE_CLK) disable iff (!RST_B) store && (|rd_chres) |=> fresh_q;
    endproperty
    a_fresh_race: assert property (p_fresh_race) else $error("fresh lost to read");

    property p_fresh_dis;
        @(posedge CORE_CLK) disable iff (!RST_B)
            store && wr && (PADDR == OFF_CHDIS) |=> fresh_q && (last_q == $past(EOC_DATA));
    endproperty
    a_fresh_dis: assert property (p_fresh_dis) else $error("fresh lost to disable");

    property p_ovr_set;
        @(posedge CORE_CLK) disable iff (!RST_B)
            store && done_q[EOC_CH] |=> ovr_q[$past(EOC_CH)];
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("channel overrun missed");

    // disable write and overrun in one cycle: both overrun flags must rise
    sequence s_ovr_race;
        wr && (PADDR == OFF_CHDIS) && store && fresh_q && done_q[EOC_CH];
    endsequence
    property p_ovr_dis;
        @(posedge CORE_CLK) disable iff (!RST_B)
            s_ovr_race |=> govr_q && ovr_q[$past(EOC_CH)];
    endproperty
    a_ovr_dis: assert property (p_ovr_dis) else $error("overrun lost to disable");

    property p_done_last;
        @(posedge CORE_CLK) disable iff (!RST_B) rd_last && !store |=> done_q == 8'h00;
    endproperty
    a_done_last: assert property (p_done_last) else $error("done kept after last read");

    property p_done_own;
        @(posedge CORE_CLK) disable iff (!RST_B)
            store && (|rd_chres) |=> done_q[$past(EOC_CH)];
    endproperty
    a_done_own: assert property (p_done_own) else $error("done of other channel lost");

    // a refused access must leave every setting alone
    property p_err_quiet;
        @(posedge CORE_CLK) disable iff (!RST_B)
            acc && !mapped |=> $stable(chen_q) && $stable(mask_q) && $stable(pd_opt_q);
    endproperty
    a_err_quiet: assert property (p_err_quiet) else $error("refused access had effect");
endmodule

// [sim/adcrs_core_model.sv]
`timescale 1ns/1ps
// adcrs_core_model: behavioural sampling core and channel multiplexer
// assumes the bench asks for a conversion end with a one-cycle trig pulse
module adcrs_core_model
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       trig,
    input  wire logic [2:0] trig_ch,
    input  wire logic       conv_start,
    output logic            eoc_valid,
    output logic [2:0]      eoc_ch,
    output logic [9:0]      eoc_data,
    output logic            conv_busy
);
    logic [3:0] cnt_q;
    logic       end_w;

    // a started conversion runs on channel 0 and ends five cycles later
    assign end_w     = trig || cnt_q == 4'h1;
    assign conv_busy = cnt_q != 4'h0;

    // data toggles outside a valid pulse so a stale value is never trusted
    always @(posedge clk)
    begin
        if (!rst_b)
        begin
            cnt_q     <= 4'h0;
            eoc_valid <= 1'b0;
            eoc_ch    <= 3'h0;
            eoc_data  <= 10'h000;
        end
        else
        begin
            cnt_q     <= conv_start ? 4'h5 : cnt_q - {3'h0, conv_busy};
            eoc_valid <= end_w;
            eoc_ch    <= trig ? trig_ch : 3'h0;
            eoc_data  <= end_w ? {7'h55, (trig ? trig_ch : 3'h0)} : ~eoc_data;
        end
    end
endmodule

// [sim/testbench.sv]
`timescale 1ns/1ps
// testbench: apb-driven checks of the converter flag and power-down logic
// assumes a zero wait state slave and the behavioural core model
module testbench;
    import adcrs_pkg::*;
    logic        clk, rst_b, psel, penable, pwrite, trig, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, eoc_v, busy, cstart, pdown, irq;
    logic [2:0]  eoc_ch, tch;
    logic [9:0]  eoc_d;
    logic [7:0]  chen;
    int          fails, checks_done;

    adcrs_top adcrs_top_i (.CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .EOC_VALID(eoc_v), .EOC_CH(eoc_ch), .EOC_DATA(eoc_d),
        .CONV_BUSY(busy), .CONV_START(cstart), .POWER_DOWN(pdown), .CH_ENABLE(chen),
        .IRQ(irq));
    adcrs_core_model adcrs_core_model_i (.clk(clk), .rst_b(rst_b), .trig(trig),
        .trig_ch(tch), .conv_start(cstart), .eoc_valid(eoc_v), .eoc_ch(eoc_ch),
        .eoc_data(eoc_d), .conv_busy(busy));

    task automatic finish_test();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one transfer; t makes a conversion end land in the access cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic t, input logic [2:0] c);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pwrite, paddr, pwdata, trig, tch} <= {1'b1, w, a, d, t, c};
        @(posedge clk);
        {penable, trig} <= 2'b10;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            fails++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        #1; // let flag updates of this edge land
    endtask

    task automatic st(input logic [31:0] e);
        apb(1'b0, OFF_STATUS, 32'h0, 1'b0, 3'h0);
        chk("status", e, rd);
    endtask

    task automatic sc_fresh();
        apb(1'b1, OFF_CHEN, 32'h7, 1'b0, 3'h0);
        chk("ch_enable", 32'h7, {24'h0, chen});
        st(32'h0);
        apb(1'b0, OFF_CHSTAT, 32'h0, 1'b1, 3'h0);
        st(32'h0001_0001);
        apb(1'b0, OFF_CHRES0, 32'h0, 1'b0, 3'h0);
        chk("chres0", 32'h2a8, rd);
        st(32'h0001_0000);
        apb(1'b0, OFF_LAST, 32'h0, 1'b0, 3'h0);
        chk("last", 32'h2a8, rd);
        st(32'h0);
        apb(1'b0, OFF_CHRES0, 32'h0, 1'b1, 3'h1);
        st(32'h0001_0002);
        apb(1'b0, OFF_LAST, 32'h0, 1'b0, 3'h0);
        chk("last", 32'h12a9, rd);
        st(32'h0);
        apb(1'b0, OFF_CHSTAT, 32'h0, 1'b1, 3'h0);
        apb(1'b0, OFF_CHRES0, 32'h0, 1'b1, 3'h1);
        apb(1'b0, OFF_STATUS, 32'h0, 1'b0, 3'h0);
        chk("done", 32'h2, rd & 32'hff);
        apb(1'b0, OFF_LAST, 32'h0, 1'b0, 3'h0);
        st(32'h0);
    endtask

    // overrun set while other reads race the conversion end
    task automatic sc_ovr();
        apb(1'b0, OFF_CHSTAT, 32'h0, 1'b1, 3'h0);
        apb(1'b0, OFF_CHRES0 + 12'h4, 32'h0, 1'b1, 3'h0);
        apb(1'b0, OFF_CHRES0, 32'h0, 1'b0, 3'h0);
        apb(1'b0, OFF_STATUS, 32'h0, 1'b1, 3'h0);
        chk("status", 32'h0003_0100, rd);
        st(32'h0003_0001);
        st(32'h0001_0001);
        apb(1'b0, OFF_LAST, 32'h0, 1'b0, 3'h0);
    endtask

    task automatic sc_dis();
        apb(1'b1, OFF_CHDIS, 32'h2, 1'b1, 3'h0);
        st(32'h0001_0001);
        apb(1'b1, OFF_CHDIS, 32'h4, 1'b1, 3'h0);
        st(32'h0003_0101);
        chk("ch_enable", 32'h1, {24'h0, chen});
        apb(1'b0, OFF_LAST, 32'h0, 1'b0, 3'h0);
        apb(1'b0, OFF_CHRES0, 32'h0, 1'b1, 3'h1);
        st(32'h0);
    endtask

    task automatic sc_pd();
        int n;
        n = 0;
        apb(1'b1, OFF_MODE, 32'h20, 1'b0, 3'h0);
        repeat (10) @(posedge clk);
        chk("power_down", 32'h0, {31'h0, pdown});
        apb(1'b1, OFF_CTRL, 32'h2, 1'b0, 3'h0);
        chk("conv_start", 32'h1, {31'h0, cstart});
        while (pdown !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        chk("power_down", 32'h1, {31'h0, pdown});
        chk("conv_start", 32'h0, {31'h0, cstart});
        if (n >= 40)
            finish_test();
        apb(1'b1, OFF_MODE, 32'h0, 1'b0, 3'h0);
    endtask

    // fresh flag left by the power-down conversion drives the interrupt
    task automatic sc_irq();
        apb(1'b0, OFF_IMASK, 32'h0, 1'b0, 3'h0);
        chk("imask", MASK_RST, rd);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b1, OFF_IEN, 32'h0001_0000, 1'b0, 3'h0);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b0, OFF_IMASK, 32'h0, 1'b0, 3'h0);
        chk("imask", 32'h0001_0000, rd);
        apb(1'b0, OFF_LAST, 32'h0, 1'b0, 3'h0);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b0, 12'h0fc, 32'h0, 1'b0, 3'h0);
        chk("pslverr", 32'h1, {31'h0, err});
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        {rst_b, psel, penable, pwrite, trig, err} = 6'h00;
        {tch, paddr, pwdata, rd} = '0;
        fails = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        sc_fresh();
        sc_ovr();
        sc_dis();
        sc_pd();
        sc_irq();
        finish_test();
    end
endmodule
